// ### core/bph_cfg.svh
`ifndef BPH_CFG_SVH
`define BPH_CFG_SVH

`define BPH_OFS_CTRL 8'h00
`define BPH_OFS_PAD 8'h04
`define BPH_OFS_IVL 8'h08
`define BPH_OFS_RF 8'h0c
`define BPH_OFS_STAT 8'h10

`define BPH_CTRL_WEN 0
`define BPH_CTRL_DPOL 1
`define BPH_CTRL_HPOL 2
`define BPH_CTRL_ATTN 3
`define BPH_CTRL_SLP 4
`define BPH_CTRL_SNIFF 5
`define BPH_CTRL_SHDN 6
`define BPH_CTRL_CLKN 7
`define BPH_CTRL_RST 8'h06

`define BPH_PAD_RST 6'h00
`define BPH_PAD_PWR 2'h0
`define BPH_PAD_DTH 1:0
`define BPH_PAD_HTD 3:2
`define BPH_PAD_CLK 5:4

`define BPH_IVL_RST 16'h0020
`define BPH_IVL_ONE 16'h0001
`define BPH_RF_RST 4'h0
`define BPH_PD_OFF 4'hf
`define BPH_STAT_ATTN 8

`define BPH_SYN_DEVW 0
`define BPH_SYN_LPO 1
`define BPH_SYN_REG 2

`endif

// ### core/bph_pkg.sv
package bph_pkg;
  typedef enum logic [2:0] {
    BPH_ST_ACTIVE = 3'b000,
    BPH_ST_SLEEP = 3'b001,
    BPH_ST_SNIFF = 3'b010,
    BPH_ST_SHDN = 3'b011
  } bph_state_t;
endpackage

// ### core/bph_sync.sv
`timescale 1ns/100ps
module bph_sync (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [2:0] d_i,
  output logic [2:0] q_o
);
  logic [2:0] s1_r;
  logic [2:0] s2_r;

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_bit
      always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          s1_r[g] <= 1'b0;
          s2_r[g] <= 1'b0;
        end else begin
          s1_r[g] <= d_i[g];
          s2_r[g] <= s1_r[g];
        end
      end
    end
  endgenerate

  assign q_o = s2_r;
endmodule

// ### core/bph_top.sv
`timescale 1ns/100ps
`include "bph_cfg.svh"
module bph_top (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic uart_mode_i,
  input wire logic host_to_device_wake_i,
  input wire logic low_power_oscillator_input_i,
  input wire logic bluetooth_regulator_enable_i,
  input wire logic wlan_clk_need_i,
  input wire logic bb_tx_active_i,
  input wire logic bb_rx_active_i,
  input wire logic bb_attn_i,
  input wire logic bb_sniff_i,
  output logic device_to_host_wake_o,
  output logic device_to_host_wake_oe_o,
  output logic clk_req_o,
  output logic clk_req_oe_o,
  output logic tx_pd_o,
  output logic rx_pd_o,
  output logic pll_pd_o,
  output logic pa_pd_o,
  output logic lpo_run_o,
  output logic inputs_en_o,
  output logic por_n_o,
  output bph_pkg::bph_state_t state_o
);
  import bph_pkg::*;

  logic [2:0] syn_q;
  logic lpo_d_r;
  logic por_n_r;
  logic srst;
  bph_state_t state_r;
  bph_state_t state_nxt;
  logic [7:0] ctrl_r;
  logic [5:0] pad_r;
  logic [15:0] ivl_r;
  logic [15:0] cnt_r;
  logic [15:0] cnt_inc;
  logic [3:0] rf_r;
  logic attn_r;
  logic [31:0] rdata_r;
  logic dth_r;
  logic dth_oe_r;
  logic clk_r;
  logic clk_oe_r;
  logic [3:0] pd_r;
  logic [3:0] pd_nxt;

  // regulator and lpo are slow async pins, synchronised like the wake input
  bph_sync u_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .d_i({bluetooth_regulator_enable_i, low_power_oscillator_input_i,
          host_to_device_wake_i}),
    .q_o(syn_q)
  );

  wire devw_s = syn_q[`BPH_SYN_DEVW];
  wire lpo_s = syn_q[`BPH_SYN_LPO];
  wire reg_s = syn_q[`BPH_SYN_REG];
  wire lpo_rise = lpo_s & ~lpo_d_r;

  // decode
  wire shdn = (state_r == BPH_ST_SHDN);
  wire wr_ok = wr_i & ~shdn;
  wire wr_ctrl = wr_ok & (addr_i == `BPH_OFS_CTRL);
  wire wr_pad = wr_ok & (addr_i == `BPH_OFS_PAD);
  wire wr_ivl = wr_ok & (addr_i == `BPH_OFS_IVL);
  wire wr_rf = wr_ok & (addr_i == `BPH_OFS_RF);
  wire wr_stat = wr_ok & (addr_i == `BPH_OFS_STAT);

  // pad function must be 0 for power-control use
  wire pad_dth = (pad_r[`BPH_PAD_DTH] == `BPH_PAD_PWR);
  wire pad_htd = (pad_r[`BPH_PAD_HTD] == `BPH_PAD_PWR);
  wire pad_clk = (pad_r[`BPH_PAD_CLK] == `BPH_PAD_PWR);
  wire wake_use = uart_mode_i & ctrl_r[`BPH_CTRL_WEN];

  // incoming wake, polarity resolved
  wire devw_act = wake_use & pad_htd & (devw_s == ctrl_r[`BPH_CTRL_DPOL]);

  wire host_need = ctrl_r[`BPH_CTRL_ATTN] | attn_r;
  wire radio_busy = bb_tx_active_i | bb_rx_active_i;
  wire sniff_cmd = bb_sniff_i | (wr_ctrl & wdata_i[`BPH_CTRL_SNIFF]);
  wire sleep_ok = ctrl_r[`BPH_CTRL_SLP] & ~devw_act & ~radio_busy & ~host_need;
  wire wake_cond = devw_act | radio_busy | host_need;
  assign cnt_inc = cnt_r + `BPH_IVL_ONE;
  wire ivl_done = lpo_rise & (cnt_inc == ivl_r);

  // anything but sleep/sniff/shutdown wants the reference clock
  wire bt_clk_need = (state_r == BPH_ST_ACTIVE) | ctrl_r[`BPH_CTRL_CLKN];
  wire clk_need = bt_clk_need | wlan_clk_need_i;

  // host wake drives the attention level with the chosen polarity
  wire dth_act = wake_use & host_need;
  wire dth_lvl = ctrl_r[`BPH_CTRL_HPOL] ? dth_act : ~dth_act;

  // status word
  wire [31:0] stat_w = {19'h0, pd_r, attn_r, uart_mode_i, wake_use, clk_r,
                        devw_act, dth_act, state_r};
  wire [31:0] rmux =
    (addr_i == `BPH_OFS_CTRL) ? {24'h0, ctrl_r} :
    (addr_i == `BPH_OFS_PAD) ? {26'h0, pad_r} :
    (addr_i == `BPH_OFS_IVL) ? {16'h0, ivl_r} :
    (addr_i == `BPH_OFS_RF) ? {28'h0, rf_r} :
    (addr_i == `BPH_OFS_STAT) ? stat_w : 32'h0;

  // por: a low regulator enable is the only way out of shutdown
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      por_n_r <= 1'b0;
    end else begin
      por_n_r <= reg_s;
    end
  end
  assign srst = ~por_n_r;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lpo_d_r <= 1'b0;
    end else begin
      lpo_d_r <= lpo_s;
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      BPH_ST_ACTIVE: begin
        if (ctrl_r[`BPH_CTRL_SHDN]) begin
          state_nxt = BPH_ST_SHDN;
        end else if (sniff_cmd & ~devw_act) begin
          state_nxt = BPH_ST_SNIFF;
        end else if (sleep_ok) begin
          state_nxt = BPH_ST_SLEEP;
        end
      end
      BPH_ST_SLEEP: begin
        if (wake_cond) begin
          state_nxt = BPH_ST_ACTIVE;
        end
      end
      BPH_ST_SNIFF: begin
        if (wake_cond | ivl_done) begin
          state_nxt = BPH_ST_ACTIVE;
        end
      end
      BPH_ST_SHDN: begin
        state_nxt = BPH_ST_SHDN;
      end
      default: begin
        state_nxt = BPH_ST_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r <= BPH_ST_ACTIVE;
    end else if (srst) begin
      state_r <= BPH_ST_ACTIVE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // interval counted in lpo ticks, restarts on each sniff entry
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_r <= 16'h0000;
    end else if (srst || state_r != BPH_ST_SNIFF) begin
      cnt_r <= 16'h0000;
    end else if (lpo_rise) begin
      cnt_r <= cnt_inc;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_r <= `BPH_CTRL_RST;
      pad_r <= `BPH_PAD_RST;
      ivl_r <= `BPH_IVL_RST;
      rf_r <= `BPH_RF_RST;
    end else if (srst) begin
      ctrl_r <= `BPH_CTRL_RST;
      pad_r <= `BPH_PAD_RST;
      ivl_r <= `BPH_IVL_RST;
      rf_r <= `BPH_RF_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= wdata_i[7:0];
      end
      if (wr_pad) begin
        pad_r <= wdata_i[5:0];
      end
      if (wr_ivl) begin
        ivl_r <= wdata_i[15:0];
      end
      if (wr_rf) begin
        rf_r <= wdata_i[3:0];
      end
    end
  end

  // baseband attention is sticky; a new event beats a write-one clear
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      attn_r <= 1'b0;
    end else if (srst) begin
      attn_r <= 1'b0;
    end else if (bb_attn_i & ~shdn) begin
      attn_r <= 1'b1;
    end else if (wr_stat & wdata_i[`BPH_STAT_ATTN]) begin
      attn_r <= 1'b0;
    end
  end

  // pd order {pa, pll, rx, tx}; radio gated per packet phase, forced by rf_r
  always_comb begin
    pd_nxt = `BPH_PD_OFF;
    if (state_r == BPH_ST_ACTIVE) begin
      pd_nxt[0] = ~bb_tx_active_i;
      pd_nxt[1] = ~bb_rx_active_i;
      pd_nxt[2] = ~radio_busy;
      pd_nxt[3] = ~bb_tx_active_i;
    end
    pd_nxt = pd_nxt | rf_r;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pd_r <= `BPH_PD_OFF;
    end else if (srst) begin
      pd_r <= `BPH_PD_OFF;
    end else begin
      pd_r <= pd_nxt;
    end
  end

  // pins: all drivers released in shutdown and while under por
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dth_r <= 1'b0;
      dth_oe_r <= 1'b0;
      clk_r <= 1'b0;
      clk_oe_r <= 1'b0;
    end else if (srst) begin
      dth_r <= 1'b0;
      dth_oe_r <= 1'b0;
      clk_r <= 1'b0;
      clk_oe_r <= 1'b0;
    end else begin
      dth_r <= dth_lvl;
      dth_oe_r <= wake_use & pad_dth & ~shdn;
      clk_r <= clk_need & ~shdn;
      clk_oe_r <= pad_clk & ~shdn;
    end
  end

  // read data lives for exactly one cycle after the strobe
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_r <= 32'h0;
    end else if (rd_i & ~shdn & ~srst) begin
      rdata_r <= rmux;
    end else begin
      rdata_r <= 32'h0;
    end
  end

  assign rdata_o = rdata_r;
  assign device_to_host_wake_o = dth_r;
  assign device_to_host_wake_oe_o = dth_oe_r;
  assign clk_req_o = clk_r;
  assign clk_req_oe_o = clk_oe_r;
  assign tx_pd_o = pd_r[0];
  assign rx_pd_o = pd_r[1];
  assign pll_pd_o = pd_r[2];
  assign pa_pd_o = pd_r[3];
  assign lpo_run_o = (state_r == BPH_ST_SNIFF);
  assign inputs_en_o = ~shdn & por_n_r;
  assign por_n_o = por_n_r;
  assign state_o = state_r;
endmodule

// ### testbench/bph_checker.sv
`timescale 1ns/100ps
module bph_checker (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic uart_mode_i,
  input wire logic bluetooth_regulator_enable_i,
  input wire logic bb_tx_active_i,
  input wire logic bb_rx_active_i,
  input wire logic device_to_host_wake_oe_o,
  input wire logic clk_req_o,
  input wire logic clk_req_oe_o,
  input wire logic tx_pd_o,
  input wire logic pll_pd_o,
  input wire logic lpo_run_o,
  input wire logic inputs_en_o,
  input wire logic por_n_o,
  input bph_pkg::bph_state_t state_o
);
  import bph_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  AST_POR_HOLD: assert property (!bluetooth_regulator_enable_i [*3] |=> !por_n_o)
    else $error("por released with regulator off");
  AST_POR_CLEAR: assert property (!por_n_o |=> state_o == BPH_ST_ACTIVE && !lpo_run_o
    && !clk_req_o && rdata_o == 32'h0)
    else $error("state kept across power-up");
  AST_RDATA_IDLE: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data outside its cycle");
  AST_TX_PD: assert property (!tx_pd_o |-> $past(bb_tx_active_i))
    else $error("tx path on without tx activity");
  AST_PLL_PD: assert property (!pll_pd_o |-> $past(bb_tx_active_i || bb_rx_active_i))
    else $error("pll on without radio activity");
  AST_SHDN_TRI: assert property (state_o == BPH_ST_SHDN ##1 state_o == BPH_ST_SHDN
    |-> !clk_req_oe_o && !device_to_host_wake_oe_o && !inputs_en_o)
    else $error("pins driven in shutdown");
  AST_SNIFF_LPO: assert property (lpo_run_o ##1 lpo_run_o |-> tx_pd_o && pll_pd_o)
    else $error("radio powered while on the oscillator");
  AST_CLK_ACTIVE: assert property (por_n_o && state_o == BPH_ST_ACTIVE ##1 por_n_o
    && state_o == BPH_ST_ACTIVE |-> clk_req_o)
    else $error("no clock request while active");
  AST_UART_ONLY: assert property (!uart_mode_i [*3] |-> !device_to_host_wake_oe_o)
    else $error("wake pin driven outside uart mode");
  cover property (state_o == BPH_ST_SLEEP);
  cover property (state_o == BPH_ST_SNIFF ##1 state_o == BPH_ST_ACTIVE);
  cover property (state_o == BPH_ST_SHDN);
endmodule
bind bph_top bph_checker bph_checker_inst (.clk_i, .rstn_i, .rd_i, .rdata_o, .uart_mode_i,
  .bluetooth_regulator_enable_i, .bb_tx_active_i, .bb_rx_active_i, .device_to_host_wake_oe_o,
  .clk_req_o, .clk_req_oe_o, .tx_pd_o, .pll_pd_o, .lpo_run_o, .inputs_en_o, .por_n_o, .state_o);

// ### testbench/bph_host_model.sv
`timescale 1ns/100ps
module bph_host_model (
  input wire logic wake_req_i,
  input wire logic dpol_i,
  input wire logic hpol_i,
  input wire logic dth_i,
  input wire logic dth_oe_i,
  input wire logic clk_req_i,
  input wire logic clk_req_oe_i,
  output logic host_to_device_wake_o,
  output logic host_awake_o,
  output logic ref_clk_on_o
);
  logic dth_last = 1'b0;
  logic dth_pin;
  always @(dth_i or dth_oe_i) if (dth_oe_i) dth_last = dth_i;
  // no pull on the wake pin: a released line must not look held
  assign dth_pin = dth_oe_i ? dth_i : !dth_last;
  assign host_to_device_wake_o = dpol_i ? wake_req_i : !wake_req_i;
  assign host_awake_o = (dth_pin == hpol_i);
  // external pull-down keeps the request low when released
  assign ref_clk_on_o = clk_req_oe_i & clk_req_i;
endmodule

// ### testbench/tb.sv
`timescale 1ns/100ps
`include "bph_cfg.svh"
module tb;
  import bph_pkg::*;
  logic clk_i, rstn_i, wr_i, rd_i, uart_mode_i, host_to_device_wake_i, bb_attn_i, bb_sniff_i;
  logic low_power_oscillator_input_i, bluetooth_regulator_enable_i, wlan_clk_need_i;
  logic bb_tx_active_i, bb_rx_active_i, device_to_host_wake_o, device_to_host_wake_oe_o;
  logic clk_req_o, clk_req_oe_o, tx_pd_o, rx_pd_o, pll_pd_o, pa_pd_o, lpo_run_o, inputs_en_o;
  logic por_n_o, wake_req, dpol, hpol, host_awake, ref_on;
  logic [7:0] addr_i;
  logic [31:0] wdata_i, rdata_o;
  bph_state_t state_o;
  int bad_count = 0;
  int n_checks = 0;
  always #4 clk_i = ~clk_i;
  bph_top bph_top_inst (.clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .uart_mode_i,
    .host_to_device_wake_i, .low_power_oscillator_input_i, .bluetooth_regulator_enable_i,
    .wlan_clk_need_i, .bb_tx_active_i, .bb_rx_active_i, .bb_attn_i, .bb_sniff_i,
    .device_to_host_wake_o, .device_to_host_wake_oe_o, .clk_req_o, .clk_req_oe_o, .tx_pd_o,
    .rx_pd_o, .pll_pd_o, .pa_pd_o, .lpo_run_o, .inputs_en_o, .por_n_o, .state_o);
  bph_host_model bph_host_model_inst (.wake_req_i(wake_req), .dpol_i(dpol), .hpol_i(hpol),
    .dth_i(device_to_host_wake_o), .dth_oe_i(device_to_host_wake_oe_o), .clk_req_i(clk_req_o),
    .clk_req_oe_i(clk_req_oe_o), .host_to_device_wake_o(host_to_device_wake_i),
    .host_awake_o(host_awake), .ref_clk_on_o(ref_on));
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, e);
  endtask
  // bounded wait, so a stuck state ends as a mismatch
  task automatic wst(input bph_state_t s);
    for (int i = 0; i < 200 && state_o !== s; i++) @(posedge clk_i);
    #1 chk(state_o, s);
  endtask
  task automatic low_power_oscillator_input(input int n);
    repeat (n) begin
      repeat (4) @(posedge clk_i);
      low_power_oscillator_input_i <= ~low_power_oscillator_input_i;
    end
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    results();
  end
  initial begin
    {clk_i, rstn_i, wr_i, rd_i, wake_req, wlan_clk_need_i, bb_tx_active_i} = '0;
    {bb_rx_active_i, bb_attn_i, bb_sniff_i, low_power_oscillator_input_i, addr_i, wdata_i} = '0;
    {uart_mode_i, bluetooth_regulator_enable_i, dpol, hpol} = 4'hf;
    repeat (10) @(posedge clk_i);
    rstn_i <= 1'b1;
    cyc(4);
    chk(por_n_o, 1'b1);
    rd(`BPH_OFS_CTRL, `BPH_CTRL_RST);
    rd(`BPH_OFS_PAD, `BPH_PAD_RST);
    rd(`BPH_OFS_IVL, `BPH_IVL_RST);
    rd(8'h14, 32'h0);
    @(posedge clk_i);
    bb_tx_active_i <= 1'b1;
    cyc(3);
    chk({tx_pd_o, rx_pd_o, pll_pd_o, pa_pd_o}, 4'h4);
    chk({clk_req_o, ref_on}, 2'h3);
    wr(`BPH_OFS_RF, 32'h9);
    cyc(2);
    chk({tx_pd_o, pa_pd_o}, 2'h3);
    wr(`BPH_OFS_RF, 32'h0);
    bb_tx_active_i <= 1'b0;
    wr(`BPH_OFS_CTRL, 32'h0f);
    cyc(3);
    chk({device_to_host_wake_oe_o, device_to_host_wake_o, host_awake}, 3'h7);
    wr(`BPH_OFS_CTRL, 32'h0b);
    hpol <= 1'b0;
    cyc(3);
    chk({device_to_host_wake_o, host_awake}, 2'h1);
    wr(`BPH_OFS_PAD, 32'h3);
    cyc(2);
    chk(device_to_host_wake_oe_o, 1'b0);
    wr(`BPH_OFS_PAD, 32'h0);
    uart_mode_i <= 1'b0;
    cyc(3);
    chk(device_to_host_wake_oe_o, 1'b0);
    wr(`BPH_OFS_CTRL, 32'h07);
    {uart_mode_i, hpol, bb_attn_i} <= 3'h7;
    @(posedge clk_i);
    bb_attn_i <= 1'b0;
    cyc(3);
    chk(device_to_host_wake_o, 1'b1);
    wr(`BPH_OFS_STAT, 32'h100);
    cyc(3);
    chk(device_to_host_wake_o, 1'b0);
    wr(`BPH_OFS_CTRL, 32'h17);
    wst(BPH_ST_SLEEP);
    cyc(2);
    chk(clk_req_o, 1'b0);
    @(posedge clk_i);
    wlan_clk_need_i <= 1'b1;
    cyc(2);
    chk(clk_req_o, 1'b1);
    @(posedge clk_i);
    wlan_clk_need_i <= 1'b0;
    wake_req <= 1'b1;
    cyc(1);
    chk(state_o, BPH_ST_SLEEP);
    cyc(3);
    chk(state_o, BPH_ST_ACTIVE);
    @(posedge clk_i);
    wake_req <= 1'b0;
    bb_rx_active_i <= 1'b1;
    cyc(8);
    chk(state_o, BPH_ST_ACTIVE);
    chk({tx_pd_o, rx_pd_o, pll_pd_o, pa_pd_o}, 4'h9);
    wr(`BPH_OFS_CTRL, 32'h07);
    bb_rx_active_i <= 1'b0;
    dpol <= 1'b0;
    wr(`BPH_OFS_CTRL, 32'h95);
    wst(BPH_ST_SLEEP);
    chk(clk_req_o, 1'b1);
    rd(`BPH_OFS_STAT, 32'h1ee1);
    @(posedge clk_i);
    wake_req <= 1'b1;
    wst(BPH_ST_ACTIVE);
    wr(`BPH_OFS_CTRL, 32'h07);
    {wake_req, dpol} <= 2'h1;
    wr(`BPH_OFS_IVL, 32'h2);
    wr(`BPH_OFS_CTRL, 32'h27);
    wst(BPH_ST_SNIFF);
    chk(lpo_run_o, 1'b1);
    low_power_oscillator_input(2);
    cyc(6);
    chk(state_o, BPH_ST_SNIFF);
    low_power_oscillator_input(1);
    wst(BPH_ST_ACTIVE);
    @(posedge clk_i);
    bb_sniff_i <= 1'b1;
    @(posedge clk_i);
    bb_sniff_i <= 1'b0;
    wst(BPH_ST_SNIFF);
    low_power_oscillator_input(4);
    wst(BPH_ST_ACTIVE);
    wr(`BPH_OFS_CTRL, 32'h47);
    wst(BPH_ST_SHDN);
    cyc(2);
    chk({clk_req_oe_o, device_to_host_wake_oe_o, inputs_en_o}, 3'h0);
    rd(`BPH_OFS_IVL, 32'h0);
    @(posedge clk_i);
    bluetooth_regulator_enable_i <= 1'b0;
    cyc(5);
    chk(por_n_o, 1'b0);
    @(posedge clk_i);
    bluetooth_regulator_enable_i <= 1'b1;
    cyc(5);
    chk(state_o, BPH_ST_ACTIVE);
    rd(`BPH_OFS_IVL, `BPH_IVL_RST);
    results();
  end
endmodule
